// [hw/pcrb_consts.svh]
// constants of the paged configuration host controller
// assumes a 32-bit apb slave port and an 8-bit paged device write port
`ifndef PCRB_CONSTS_SVH
`define PCRB_CONSTS_SVH

// ****************************************************
// apb register offsets and fields
// ****************************************************
`define PCRB_OFS_CMD 12'h000
`define PCRB_OFS_PAGE 12'h004
`define PCRB_OFS_STATUS 12'h008
`define PCRB_CMD_MSB 2
`define PCRB_ST_BUSY 0
`define PCRB_ST_DONE 1
`define PCRB_ST_OFS_READ 2
`define PCRB_ST_OFS_LOAD 3
`define PCRB_ST_LANE_LSB 4
`define PCRB_ST_LANE_MSB 7
`define PCRB_LANES_DEF 4'h8
`define PCRB_LANES_FOUR 4'h4

// ****************************************************
// device page values
// ****************************************************
`define PCRB_SPG_OFS_READ 16'h0000
`define PCRB_SPG_OFS_LOAD 16'h0500
`define PCRB_PPG_MAIN 16'h6800
`define PCRB_PPG_LINKD 16'h6900
`define PCRB_PPG_LINKA 16'h6A00
`define PCRB_PPG_OFS 16'h6100

// ****************************************************
// device addresses, bank in the top nibble
// ****************************************************
`define PCRB_DA_SWRST 16'h0000
`define PCRB_DA_SPG_LO 16'h0001
`define PCRB_DA_SPG_HI 16'h0002
`define PCRB_DA_ANA_PAGE 16'h0011
`define PCRB_DA_PDN 16'h0026
`define PCRB_DA_PPG_LO 16'h4003
`define PCRB_DA_PPG_HI 16'h4004
`define PCRB_DA_APPLY 16'h6000
`define PCRB_DA_LINK_MODE 16'h6001
`define PCRB_DA_SER_PLL 16'h6016
`define PCRB_DA_REORD_A 16'h6031
`define PCRB_DA_REORD_B 16'h6032
`define PCRB_DA_DEC_SEL 16'h6041
`define PCRB_DA_DEC_CTL 16'h604D
`define PCRB_DA_ORD1 16'h6052
`define PCRB_DA_ORD2 16'h6072

// ****************************************************
// device write data
// ****************************************************
`define PCRB_D_ZERO 8'h00
`define PCRB_D_SWRST 8'h01
`define PCRB_D_MASTER_PG 8'h80
`define PCRB_D_ADC_PG 8'h0F
`define PCRB_D_PDN_ALL 8'hC0
`define PCRB_D_PG_MAIN 8'h68
`define PCRB_D_PG_LINKD 8'h69
`define PCRB_D_PG_LINKA 8'h6A
`define PCRB_D_40X 8'h02
`define PCRB_D_DEC2 8'h12
`define PCRB_D_DEC_EN 8'h08
`define PCRB_D_ORD2 8'h08
`define PCRB_D_ORD1 8'h80
`define PCRB_D_APPLY 8'h01
`define PCRB_D_REORD 8'h0A
`define PCRB_D_MODE4222 8'h31

// ****************************************************
// sequence table bounds
// ****************************************************
`define PCRB_SEQ_RST_B 5'h00
`define PCRB_SEQ_RST_E 5'h00
`define PCRB_SEQ_PAGE_B 5'h01
`define PCRB_SEQ_PAGE_E 5'h02
`define PCRB_SEQ_PDN_B 5'h03
`define PCRB_SEQ_PDN_E 5'h04
`define PCRB_SEQ_LANE_B 5'h05
`define PCRB_SEQ_LANE_E 5'h09
`define PCRB_SEQ_DEC_B 5'h0A
`define PCRB_SEQ_DEC_E 5'h16

`endif

// [hw/pcrb_host.sv]
// host controller that programs the paged configuration registers
// assumes an apb master on pclk and a device write port on pclk
//
// Behaviour
// - power down: write 80h to 0-011h, then C0h to 0-026h
// - link digital page: 69h to 4-004h, then 00h to 4-003h
// - two lanes per channel: 02h to 6-001h on link digital page
// - link analog page 6Ah at 4-004h, then 02h to 6-016h
// - decimation starts with 68h to 4-004h and 00h to 4-003h
// - decimate by two low-pass: 12h to 6-041h
// - 08h to 6-04Dh, then 08h to 6-072h and 80h to 6-052h
// - main digital writes apply after 01h then 00h to 6-000h
// - four-lane mode: 0Ah to 6-031h and 0Ah to 6-032h
// - finish four-lane decimation with 31h to 6-001h
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "pcrb_consts.svh"

module pcrb_host (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic dev_wr,
    output logic [15:0] dev_addr,
    output logic [7:0] dev_wdata,
    input wire logic dev_ack
);

    // ****************************************************
    // state and table
    // ****************************************************
    pcrb_pkg::pcrb_regs_t r_ff;
    pcrb_pkg::pcrb_regs_t nxt_r;
    logic [15:0] rom_addr;
    logic [7:0] rom_data;
    logic setup;
    logic access;
    logic ack;
    logic [2:0] wcmd;

    pcrb_seq_rom pcrb_seq_rom_inst (
        .idx(r_ff.idx),
        .page(r_ff.page),
        .addr(rom_addr),
        .data(rom_data)
    );

    assign setup = psel & ~penable;
    assign access = psel & penable & r_ff.pready;
    assign ack = dev_wr & dev_ack;
    assign wcmd = pwdata[`PCRB_CMD_MSB:0];

    // ****************************************************
    // next state
    // ****************************************************
    always_comb begin
        nxt_r = r_ff;
        nxt_r.pready = 1'b0;
        if (setup) begin
            nxt_r.pready = 1'b1;
            nxt_r.pslverr = 1'b0;
            nxt_r.prdata = 32'h0000_0000;
            if (paddr == `PCRB_OFS_CMD) begin
                if (pwrite && (r_ff.st != pcrb_pkg::PCRB_IDLE ||
                    wcmd == pcrb_pkg::PCRB_CMD_NONE ||
                    wcmd > pcrb_pkg::PCRB_CMD_DEC2)) begin
                    nxt_r.pslverr = 1'b1;
                end
            end else if (paddr == `PCRB_OFS_PAGE) begin
                nxt_r.prdata = {16'h0000, r_ff.page};
                if (pwrite && r_ff.st != pcrb_pkg::PCRB_IDLE) begin
                    nxt_r.pslverr = 1'b1;
                end
            end else if (paddr == `PCRB_OFS_STATUS) begin
                nxt_r.prdata[`PCRB_ST_BUSY] =
                    (r_ff.st != pcrb_pkg::PCRB_IDLE);
                nxt_r.prdata[`PCRB_ST_DONE] = r_ff.done;
                nxt_r.prdata[`PCRB_ST_OFS_READ] =
                    (r_ff.page == `PCRB_SPG_OFS_READ);
                nxt_r.prdata[`PCRB_ST_OFS_LOAD] =
                    (r_ff.page == `PCRB_SPG_OFS_LOAD);
                nxt_r.prdata[`PCRB_ST_LANE_MSB:`PCRB_ST_LANE_LSB] =
                    r_ff.lanes;
            end else begin
                nxt_r.pslverr = 1'b1;
            end
        end
        // register writes
        if (access && pwrite && !r_ff.pslverr) begin
            if (paddr == `PCRB_OFS_CMD) begin
                nxt_r.cmd = pcrb_pkg::pcrb_cmd_t'(wcmd);
                nxt_r.st = pcrb_pkg::PCRB_LOAD;
                nxt_r.done = 1'b0;
                case (wcmd)
                    pcrb_pkg::PCRB_CMD_RESET: begin
                        nxt_r.idx = `PCRB_SEQ_RST_B;
                        nxt_r.last = `PCRB_SEQ_RST_E;
                    end
                    pcrb_pkg::PCRB_CMD_PAGE: begin
                        nxt_r.idx = `PCRB_SEQ_PAGE_B;
                        nxt_r.last = `PCRB_SEQ_PAGE_E;
                    end
                    pcrb_pkg::PCRB_CMD_PDN: begin
                        nxt_r.idx = `PCRB_SEQ_PDN_B;
                        nxt_r.last = `PCRB_SEQ_PDN_E;
                    end
                    pcrb_pkg::PCRB_CMD_LANE: begin
                        nxt_r.idx = `PCRB_SEQ_LANE_B;
                        nxt_r.last = `PCRB_SEQ_LANE_E;
                    end
                    default: begin
                        nxt_r.idx = `PCRB_SEQ_DEC_B;
                        nxt_r.last = `PCRB_SEQ_DEC_E;
                    end
                endcase
            end else if (paddr == `PCRB_OFS_PAGE) begin
                nxt_r.page = pwdata[15:0];
            end else if (paddr == `PCRB_OFS_STATUS) begin
                if (pwdata[`PCRB_ST_DONE]) begin
                    nxt_r.done = 1'b0;
                end
            end
        end
        // sequencer
        case (r_ff.st)
            pcrb_pkg::PCRB_LOAD: begin
                nxt_r.dev_addr = rom_addr;
                nxt_r.dev_wdata = rom_data;
                nxt_r.st = pcrb_pkg::PCRB_REQ;
            end
            pcrb_pkg::PCRB_REQ: begin
                if (dev_ack) begin
                    if (r_ff.idx == r_ff.last) begin
                        nxt_r.st = pcrb_pkg::PCRB_IDLE;
                        nxt_r.done = 1'b1;
                        if (r_ff.cmd == pcrb_pkg::PCRB_CMD_RESET) begin
                            nxt_r.lanes = `PCRB_LANES_DEF;
                        end else if (r_ff.cmd == pcrb_pkg::PCRB_CMD_LANE ||
                            r_ff.cmd == pcrb_pkg::PCRB_CMD_DEC2) begin
                            nxt_r.lanes = `PCRB_LANES_FOUR;
                        end
                    end else begin
                        nxt_r.idx = r_ff.idx + 5'h01;
                        nxt_r.st = pcrb_pkg::PCRB_LOAD;
                    end
                end
            end
            default: begin
                nxt_r.st = nxt_r.st;
            end
        endcase
    end

    // ****************************************************
    // registers
    // ****************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_ff.st <= pcrb_pkg::PCRB_IDLE;
            r_ff.cmd <= pcrb_pkg::PCRB_CMD_NONE;
            r_ff.idx <= 5'h00;
            r_ff.last <= 5'h00;
            r_ff.page <= `PCRB_SPG_OFS_READ;
            r_ff.done <= 1'b0;
            r_ff.lanes <= `PCRB_LANES_DEF;
            r_ff.prdata <= 32'h0000_0000;
            r_ff.pready <= 1'b0;
            r_ff.pslverr <= 1'b0;
            r_ff.dev_addr <= 16'h0000;
            r_ff.dev_wdata <= 8'h00;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign prdata = r_ff.prdata;
    assign pready = r_ff.pready;
    assign pslverr = r_ff.pslverr & r_ff.pready;
    assign dev_wr = (r_ff.st == pcrb_pkg::PCRB_REQ);
    assign dev_addr = r_ff.dev_addr;
    assign dev_wdata = r_ff.dev_wdata;

    // ****************************************************
    // checks
    // ****************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_rst_bits;
        dev_wr && dev_addr == `PCRB_DA_SWRST |->
            dev_wdata[6:1] == 6'h00 && (dev_wdata[7] || dev_wdata[0]);
    endproperty
    a_rst_bits: assert property (p_rst_bits)
        else $error("reset register write has bad bits");

    property p_rst_lanes;
        ack && r_ff.cmd == pcrb_pkg::PCRB_CMD_RESET |=>
            r_ff.lanes == `PCRB_LANES_DEF && r_ff.done && !dev_wr;
    endproperty
    a_rst_lanes: assert property (p_rst_lanes)
        else $error("lane count not eight after soft reset");

    property p_page_lo;
        dev_wr && dev_addr == `PCRB_DA_SPG_LO |->
            dev_wdata == r_ff.page[7:0];
    endproperty
    a_page_lo: assert property (p_page_lo)
        else $error("page low byte wrong");

    property p_page_hi;
        ack && dev_addr == `PCRB_DA_SPG_LO |-> ##2 (dev_wr &&
            dev_addr == `PCRB_DA_SPG_HI && dev_wdata == r_ff.page[15:8]);
    endproperty
    a_page_hi: assert property (p_page_hi)
        else $error("page high byte missing");

    property p_pdn;
        ack && dev_addr == `PCRB_DA_ANA_PAGE &&
            dev_wdata == `PCRB_D_MASTER_PG |-> ##2 (dev_wr &&
            dev_addr == `PCRB_DA_PDN && dev_wdata == `PCRB_D_PDN_ALL);
    endproperty
    a_pdn: assert property (p_pdn)
        else $error("power down write missing");

    property p_linkd;
        ack && dev_addr == `PCRB_DA_PPG_HI &&
            dev_wdata == `PCRB_D_PG_LINKD |-> ##2 (dev_wr &&
            dev_addr == `PCRB_DA_PPG_LO && dev_wdata == `PCRB_D_ZERO);
    endproperty
    a_linkd: assert property (p_linkd)
        else $error("link digital page low byte missing");

    property p_40x;
        ack && r_ff.cmd == pcrb_pkg::PCRB_CMD_LANE &&
            dev_addr == `PCRB_DA_PPG_LO |-> ##2 (dev_wr &&
            dev_addr == `PCRB_DA_LINK_MODE && dev_wdata == `PCRB_D_40X);
    endproperty
    a_40x: assert property (p_40x)
        else $error("digital 40x write missing");

    property p_pll;
        ack && dev_addr == `PCRB_DA_PPG_HI &&
            dev_wdata == `PCRB_D_PG_LINKA |-> ##2 (dev_wr &&
            dev_addr == `PCRB_DA_SER_PLL && dev_wdata == `PCRB_D_40X);
    endproperty
    a_pll: assert property (p_pll)
        else $error("serializer pll write missing");

    property p_main;
        ack && dev_addr == `PCRB_DA_PPG_HI &&
            dev_wdata == `PCRB_D_PG_MAIN |-> ##2 (dev_wr &&
            dev_addr == `PCRB_DA_PPG_LO && dev_wdata == `PCRB_D_ZERO);
    endproperty
    a_main: assert property (p_main)
        else $error("main page low byte missing");

    property p_dec;
        dev_wr && dev_addr == `PCRB_DA_DEC_SEL |->
            dev_wdata == `PCRB_D_DEC2 && r_ff.cmd == pcrb_pkg::PCRB_CMD_DEC2;
    endproperty
    a_dec: assert property (p_dec)
        else $error("decimation select wrong");

    property p_dec_en;
        ack && dev_addr == `PCRB_DA_DEC_SEL |-> ##2 (dev_wr &&
            dev_addr == `PCRB_DA_DEC_CTL && dev_wdata == `PCRB_D_DEC_EN);
    endproperty
    a_dec_en: assert property (p_dec_en)
        else $error("decimation filter enable write missing");

    property p_ord2;
        ack && dev_addr == `PCRB_DA_DEC_CTL |-> ##2 (dev_wr &&
            dev_addr == `PCRB_DA_ORD2 && dev_wdata == `PCRB_D_ORD2);
    endproperty
    a_ord2: assert property (p_ord2)
        else $error("second lane order enable write missing");

    property p_ord1;
        ack && dev_addr == `PCRB_DA_ORD2 |-> ##2 (dev_wr &&
            dev_addr == `PCRB_DA_ORD1 && dev_wdata == `PCRB_D_ORD1);
    endproperty
    a_ord1: assert property (p_ord1)
        else $error("first lane order enable write missing");

    property p_apply;
        ack && dev_addr == `PCRB_DA_APPLY && dev_wdata == `PCRB_D_APPLY
            |-> ##2 (dev_wr && dev_addr == `PCRB_DA_APPLY &&
            dev_wdata == `PCRB_D_ZERO);
    endproperty
    a_apply: assert property (p_apply)
        else $error("apply strobe not released");

    property p_reord;
        ack && dev_addr == `PCRB_DA_REORD_A |-> ##2 (dev_wr &&
            dev_addr == `PCRB_DA_REORD_B && dev_wdata == `PCRB_D_REORD);
    endproperty
    a_reord: assert property (p_reord)
        else $error("channel b reorder missing");

    property p_mode;
        ack && dev_addr == `PCRB_DA_REORD_B |-> ##2 (dev_wr &&
            dev_addr == `PCRB_DA_LINK_MODE &&
            dev_wdata == `PCRB_D_MODE4222);
    endproperty
    a_mode: assert property (p_mode)
        else $error("link mode write missing");

    property p_apb;
        setup |=> pready ##1 !pready;
    endproperty
    a_apb: assert property (p_apb)
        else $error("apb answer not one cycle after setup");

    property p_refused;
        pready && pslverr && r_ff.st == pcrb_pkg::PCRB_IDLE |=>
            r_ff.st == pcrb_pkg::PCRB_IDLE;
    endproperty
    a_refused: assert property (p_refused)
        else $error("refused transfer started a command");

    property p_done;
        ack && r_ff.idx == r_ff.last |=> r_ff.done && !dev_wr;
    endproperty
    a_done: assert property (p_done)
        else $error("done not set at end of sequence");

    c_pdn: cover property (ack && dev_addr == `PCRB_DA_PDN);
    c_dec: cover property (ack && dev_wdata == `PCRB_D_MODE4222 &&
        r_ff.cmd == pcrb_pkg::PCRB_CMD_DEC2);
    c_refused: cover property (pready && pslverr);
    c_page: cover property (ack && dev_addr == `PCRB_DA_SPG_HI);

endmodule

// [hw/pcrb_pkg.sv]
// types of the paged configuration host controller
// assumes pcrb_consts.svh on the include path
package pcrb_pkg;

    typedef enum logic [2:0] {
        PCRB_IDLE = 3'h1,
        PCRB_LOAD = 3'h2,
        PCRB_REQ = 3'h4
    } pcrb_state_t;

    typedef enum logic [2:0] {
        PCRB_CMD_NONE = 3'h0,
        PCRB_CMD_RESET = 3'h1,
        PCRB_CMD_PAGE = 3'h2,
        PCRB_CMD_PDN = 3'h3,
        PCRB_CMD_LANE = 3'h4,
        PCRB_CMD_DEC2 = 3'h5
    } pcrb_cmd_t;

    typedef struct packed {
        pcrb_state_t st;
        pcrb_cmd_t cmd;
        logic [4:0] idx;
        logic [4:0] last;
        logic [15:0] page;
        logic done;
        logic [3:0] lanes;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [15:0] dev_addr;
        logic [7:0] dev_wdata;
    } pcrb_regs_t;

endpackage

// [hw/pcrb_seq_rom.sv]
// constant table of device write sequences
// assumes index from the host sequencer, page from its page register
`timescale 1ns/1ps
`include "pcrb_consts.svh"

module pcrb_seq_rom (
    input wire logic [4:0] idx,
    input wire logic [15:0] page,
    output logic [15:0] addr,
    output logic [7:0] data
);

    // ****************************************************
    // table lookup
    // ****************************************************
    always_comb begin
        addr = `PCRB_DA_SWRST;
        data = `PCRB_D_ZERO;
        case (idx)
            5'h00: begin addr = `PCRB_DA_SWRST; data = `PCRB_D_SWRST; end
            5'h01: begin addr = `PCRB_DA_SPG_LO; data = page[7:0]; end
            5'h02: begin addr = `PCRB_DA_SPG_HI; data = page[15:8]; end
            5'h03: begin addr = `PCRB_DA_ANA_PAGE; data = `PCRB_D_MASTER_PG; end
            5'h04: begin addr = `PCRB_DA_PDN; data = `PCRB_D_PDN_ALL; end
            5'h05: begin addr = `PCRB_DA_PPG_HI; data = `PCRB_D_PG_LINKD; end
            5'h06: begin addr = `PCRB_DA_PPG_LO; data = `PCRB_D_ZERO; end
            5'h07: begin addr = `PCRB_DA_LINK_MODE; data = `PCRB_D_40X; end
            5'h08: begin addr = `PCRB_DA_PPG_HI; data = `PCRB_D_PG_LINKA; end
            5'h09: begin addr = `PCRB_DA_SER_PLL; data = `PCRB_D_40X; end
            5'h0A: begin addr = `PCRB_DA_PPG_HI; data = `PCRB_D_PG_MAIN; end
            5'h0B: begin addr = `PCRB_DA_PPG_LO; data = `PCRB_D_ZERO; end
            5'h0C: begin addr = `PCRB_DA_DEC_SEL; data = `PCRB_D_DEC2; end
            5'h0D: begin addr = `PCRB_DA_DEC_CTL; data = `PCRB_D_DEC_EN; end
            5'h0E: begin addr = `PCRB_DA_ORD2; data = `PCRB_D_ORD2; end
            5'h0F: begin addr = `PCRB_DA_ORD1; data = `PCRB_D_ORD1; end
            5'h10: begin addr = `PCRB_DA_APPLY; data = `PCRB_D_APPLY; end
            5'h11: begin addr = `PCRB_DA_APPLY; data = `PCRB_D_ZERO; end
            5'h12: begin addr = `PCRB_DA_PPG_HI; data = `PCRB_D_PG_LINKD; end
            5'h13: begin addr = `PCRB_DA_PPG_LO; data = `PCRB_D_ZERO; end
            5'h14: begin addr = `PCRB_DA_REORD_A; data = `PCRB_D_REORD; end
            5'h15: begin addr = `PCRB_DA_REORD_B; data = `PCRB_D_REORD; end
            5'h16: begin addr = `PCRB_DA_LINK_MODE; data = `PCRB_D_MODE4222; end
            default: begin addr = `PCRB_DA_SWRST; data = `PCRB_D_ZERO; end
        endcase
    end

endmodule

// [tb/pcrb_dev_model.sv]
// behavioural model of the paged converter config registers
// assumes the host write port of pcrb_host on the same pclk
`timescale 1ns/1ps
`include "pcrb_consts.svh"

module pcrb_dev_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] ack_wait,
    input wire logic dev_wr,
    input wire logic [15:0] dev_addr,
    input wire logic [7:0] dev_wdata,
    output logic dev_ack
);
    // ****************************************************
    // register state and write log
    // ****************************************************
    logic [7:0] spg_lo, spg_hi, ana_pg, ppg_lo, ppg_hi, dec_pend;
    logic [3:0] cnt, lanes;
    logic armed, dec_active, pdn_all, pll40x;
    logic [23:0] wlog [0:31];
    int n_log;
    wire logic [15:0] spg = {spg_hi, spg_lo};
    wire logic [15:0] ppg = {ppg_hi, ppg_lo};
    wire logic ofs_read = (spg == `PCRB_SPG_OFS_READ);
    wire logic ofs_load = (spg == `PCRB_SPG_OFS_LOAD);

    // ****************************************************
    // write port with adjustable ack delay
    // ****************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dev_ack <= 1'b0;
            cnt <= 4'h0;
            {spg_lo, spg_hi, ana_pg, ppg_lo, ppg_hi, dec_pend} <= '0;
            {armed, dec_active, pdn_all, pll40x} <= '0;
            lanes <= `PCRB_LANES_DEF;
            n_log <= 0;
        end else begin
            dev_ack <= 1'b0;
            if (dev_wr && !dev_ack && cnt < ack_wait) begin
                cnt <= cnt + 4'h1;
            end else if (dev_wr && !dev_ack) begin
                dev_ack <= 1'b1;
                cnt <= 4'h0;
                if (n_log < 32) begin
                    wlog[n_log] <= {dev_addr, dev_wdata};
                end
                n_log <= n_log + 1;
                case (dev_addr)
                    `PCRB_DA_SWRST: if (dev_wdata[7] || dev_wdata[0]) begin
                        {spg_lo, spg_hi, ana_pg, ppg_lo, ppg_hi} <= '0;
                        lanes <= `PCRB_LANES_DEF;
                    end
                    `PCRB_DA_SPG_LO: spg_lo <= dev_wdata;
                    `PCRB_DA_SPG_HI: spg_hi <= dev_wdata;
                    `PCRB_DA_ANA_PAGE: ana_pg <= dev_wdata;
                    `PCRB_DA_PDN: if (ana_pg == `PCRB_D_MASTER_PG) begin
                        pdn_all <= (dev_wdata == `PCRB_D_PDN_ALL);
                    end
                    `PCRB_DA_PPG_LO: ppg_lo <= dev_wdata;
                    `PCRB_DA_PPG_HI: ppg_hi <= dev_wdata;
                    `PCRB_DA_LINK_MODE: if (ppg == `PCRB_PPG_LINKD) begin
                        lanes <= `PCRB_LANES_FOUR;
                    end
                    `PCRB_DA_SER_PLL: if (ppg[15:8] == `PCRB_D_PG_LINKA) begin
                        pll40x <= (dev_wdata == `PCRB_D_40X);
                    end
                    `PCRB_DA_DEC_SEL: if (ppg == `PCRB_PPG_MAIN) begin
                        dec_pend <= dev_wdata;
                    end
                    `PCRB_DA_APPLY: if (ppg == `PCRB_PPG_MAIN) begin
                        armed <= (dev_wdata == `PCRB_D_APPLY);
                        if (armed && dev_wdata == `PCRB_D_ZERO) begin
                            dec_active <= (dec_pend == `PCRB_D_DEC2);
                        end
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule

// [tb/pcrb_host_tb.sv]
// self-checking bench of the paged config host controller
// assumes pcrb_host on apb and the device model on its write port
`timescale 1ns/1ps
`include "pcrb_consts.svh"

module pcrb_host_tb;
    // ****************************************************
    // signals and instances
    // ****************************************************
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic dev_wr, dev_ack;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] dev_addr;
    logic [7:0] dev_wdata;
    logic [3:0] ack_wait;
    logic e;
    int num_errors = 0;
    int total_checks = 0;
    logic [23:0] exp_log [0:22] = '{
        24'h000100, 24'h000205,
        24'h001180, 24'h0026C0,
        24'h400469, 24'h400300, 24'h600102,
        24'h40046A, 24'h601602,
        24'h400468, 24'h400300, 24'h604112,
        24'h604D08, 24'h607208, 24'h605280,
        24'h600001, 24'h600000,
        24'h400469, 24'h400300, 24'h60310A, 24'h60320A,
        24'h600131,
        24'h000001};

    pcrb_host pcrb_host_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dev_wr(dev_wr), .dev_addr(dev_addr),
        .dev_wdata(dev_wdata), .dev_ack(dev_ack));
    pcrb_dev_model pcrb_dev_model_inst (.pclk(pclk), .presetn(presetn),
        .ack_wait(ack_wait), .dev_wr(dev_wr), .dev_addr(dev_addr),
        .dev_wdata(dev_wdata), .dev_ack(dev_ack));

    // ****************************************************
    // apb tasks and compare
    // ****************************************************
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 100) num_errors++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic x);
        apb(1'b1, a, d);
        cmp({31'h0, e}, {31'h0, x});
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x,
                      input logic xe);
        apb(1'b0, a, 32'h0);
        cmp({31'h0, e}, {31'h0, xe});
        if (!xe) cmp(r, x);
    endtask

    task automatic wait_done(input logic [31:0] x);
        int n;
        n = 0;
        apb(1'b0, `PCRB_OFS_STATUS, 32'h0);
        while (r[`PCRB_ST_DONE] !== 1'b1 && n < 300) begin
            apb(1'b0, `PCRB_OFS_STATUS, 32'h0);
            n++;
        end
        cmp(r, x);
    endtask

    task automatic run(input logic [31:0] c, input logic [31:0] x);
        wr(`PCRB_OFS_CMD, c, 1'b0);
        wait_done(x);
    endtask

    task automatic conclude;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ****************************************************
    // clock, watchdog and test sequence
    // ****************************************************
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    initial begin
        #(40 * 30000);
        num_errors++;
        conclude;
    end

    initial begin
        {presetn, psel, penable, pwrite} = '0;
        paddr = '0;
        pwdata = '0;
        ack_wait = 4'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`PCRB_OFS_STATUS, 32'h84, 1'b0);
        wr(`PCRB_OFS_PAGE, 32'h0500, 1'b0);
        rd(`PCRB_OFS_PAGE, 32'h0500, 1'b0);
        rd(`PCRB_OFS_STATUS, 32'h88, 1'b0);
        ack_wait <= 4'h3;
        run(32'h2, 32'h8A);
        cmp(pcrb_dev_model_inst.spg, 32'h0500);
        cmp(pcrb_dev_model_inst.ofs_load, 32'h1);
        wr(`PCRB_OFS_STATUS, 32'h2, 1'b0);
        rd(`PCRB_OFS_STATUS, 32'h88, 1'b0);
        ack_wait <= 4'h0;
        run(32'h3, 32'h8A);
        cmp(pcrb_dev_model_inst.pdn_all, 32'h1);
        rd(12'h00C, 32'h0, 1'b1);
        wr(`PCRB_OFS_CMD, 32'h0, 1'b1);
        wr(`PCRB_OFS_CMD, 32'h6, 1'b1);
        ack_wait <= 4'hF;
        wr(`PCRB_OFS_CMD, 32'h4, 1'b0);
        rd(`PCRB_OFS_STATUS, 32'h89, 1'b0);
        wr(`PCRB_OFS_CMD, 32'h3, 1'b1);
        wr(`PCRB_OFS_PAGE, 32'h0, 1'b1);
        wait_done(32'h4A);
        cmp(pcrb_dev_model_inst.pll40x, 32'h1);
        ack_wait <= 4'h1;
        run(32'h5, 32'h4A);
        cmp(pcrb_dev_model_inst.dec_active, 32'h1);
        run(32'h1, 32'h8A);
        cmp(pcrb_dev_model_inst.spg, 32'h0);
        cmp(pcrb_dev_model_inst.n_log, 32'd23);
        for (int i = 0; i < 23; i++) begin
            cmp({8'h0, pcrb_dev_model_inst.wlog[i]}, {8'h0, exp_log[i]});
        end
        conclude;
    end
endmodule
